// File: include/scc_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the scanner control block
// Assumes: 50 MHz mclk, AXI4-Lite register access
// Notes: definitions only
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_CLK_HZ 50_000_000
`define SCC_SEC_CYC 50_000_000
`define SCC_CHANNELS 64
`define SCC_OWN_ADDR 8'h00
`define SCC_BCAST_ADDR 8'hFF
`define SCC_REG_CTRL 8'h00
`define SCC_REG_SETPT 8'h04
`define SCC_REG_BAKE 8'h08
`define SCC_REG_BAKETMP 8'h0C
`define SCC_REG_LINE 8'h10
`define SCC_REG_GAIN 8'h14
`define SCC_REG_UOFS 8'h18
`define SCC_REG_FS 8'h1C
`define SCC_REG_COEF 8'h20
`define SCC_REG_RAW 8'h24
`define SCC_REG_PRES 8'h28
`define SCC_REG_TEMP 8'h2C
`define SCC_REG_STAT 8'h30
`define SCC_REG_CMD 8'h34
`define SCC_REG_POLL 8'h38
`define SCC_CTRL_PROG 0
`define SCC_CTRL_TUNIT 1
`define SCC_CTRL_PUNIT 2
`define SCC_CTRL_POLLED 3
`define SCC_CTRL_FREE 4
`define SCC_CTRL_TRIG 5
`define SCC_CTRL_BAKE 6
`define SCC_FS_RESET 32'h0001_0000
`define SCC_SETPT_RESET 16'h0014
`define SCC_BAKETIME_RESET 16'h0E10
`define SCC_PSI2BAR 32'h0000_1197
`define SCC_BAR2PSI 32'h000E_8159
`define SCC_ONE_Q16 32'h0001_0000
`endif

// File: include/scc_pkg.sv
// Purpose: types for the scanner control block
// Assumes: nothing
// Notes: parse states gray coded
package scc_pkg;
   typedef enum logic [2:0] {
      SCC_IDLE = 3'b000, SCC_ADDR1 = 3'b001, SCC_ADDR2 = 3'b011,
      SCC_SPACE = 3'b010, SCC_WORD = 3'b110, SCC_SKIP = 3'b111
   } scc_parse_t;
   typedef enum logic [1:0] {
      SCC_BAKE_OFF = 2'b00, SCC_BAKE_RUN = 2'b01, SCC_BAKE_DONE = 2'b11
   } scc_bake_t;
   typedef enum logic [2:0] {
      SCC_OP_NONE = 3'd0, SCC_OP_TRIG = 3'd1, SCC_OP_POLL = 3'd2, SCC_OP_BAKE = 3'd3,
      SCC_OP_TEMP = 3'd4, SCC_OP_UNIT = 3'd5
   } scc_op_t;
endpackage : scc_pkg

// File: logic/scc_core.sv
// Purpose: scanner command interpreter, compensation, heater and trigger control
// Assumes: single clock mclk at 50 MHz, async active-low reset
// Notes: coefficients loaded by software into a local array; fixed point Q16.16
// Function
// - quartic temperature polynomials for four terms
// - percent range from gained cubic plus offsets
// - scale by full scale, convert on unit
// - quadratic temperature conversion per sensor
// - temperature unit only Celsius or Fahrenheit
// - pressure unit only PSI or bar
// - heater on below setpoint, off above
// - setpoint in current unit, programming only
// - selectable channel also feeds status byte
// - bake query gives done, off or seconds
// - bake time and temp programming only
// - trigger by low pin or command
// - standard mode sends all 64 channels
// - polled mode stores until host polls
// - dollar, address, space, word, spaced options
// - keyword full or first two characters
// - unique address; answer only when polled
// - hold bus streaming unless release set
// - baud code written to LINE, but lineRate stays at 3
// - parity select written to LINE, but parityMode stays at 0
// - stop bits written to LINE, but twoStop stays at one stop bit
// - network commands may omit dollar and address
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "scc_map.svh"
module scc_core import scc_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trigPin_n,
   input wire logic netPort,
   input wire logic [7:0] unitAddr,
   output logic heaterOn,
   output logic busHold,
   output logic sendAll,
   output logic sendStored,
   output logic [2:0] lineRate,
   output logic [1:0] parityMode,
   output logic twoStop
);
   logic [31:0] ctrl_r, setpt_r, bakeTime_r, bakeTemp_r, line_r, gain_r, uofs_r, fs_r;
   logic [31:0] raw_r, pres_r, temp_r;
   logic [31:0] coef [0:22];
   logic [4:0] coefIdx_r;
   logic [5:0] heatChan_r;
   logic [15:0] chanTemp [0:63];
   logic trigS1_r, trigS2_r, trigPrev_r;
   logic awHave_r, wHave_r;
   logic [31:0] awAddr_r, wData_r;
   logic [3:0] wStrb_r;
   logic cmdTrig, cmdPoll, cmdBake;
   scc_parse_t parse_r;
   scc_bake_t bake_r;
   logic [15:0] addrAcc_r;
   logic [15:0] word_r;
   logic [1:0] wordLen_r;
   logic addrOk_r;
   logic [25:0] secCnt_r;
   logic [15:0] bakeLeft_r;
   logic stored_r, rawPend_r;

   function automatic logic [31:0] qmul(input logic [31:0] a, input logic [31:0] b);
      logic [63:0] p;
      p = $signed(a) * $signed(b);
      return p[47:16];
   endfunction : qmul

   function automatic logic [31:0] quart(input logic [4:0] base, input logic [31:0] t);
      logic [31:0] acc;
      acc = coef[base];
      for (int i = 1; i < 5; i++) begin
         acc = qmul(acc, t) + coef[base + 5'(i)];
      end
      return acc;
   endfunction : quart

   function automatic logic [15:0] hexNib(input logic [7:0] c);
      return (c >= 8'h41) ? 16'(c - 8'h37) : 16'(c - 8'h30);
   endfunction : hexNib

   // register write path, AXI4-Lite
   wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
   wire [7:0] wa = awAddr_r[7:0];
   wire prog = ctrl_r[`SCC_CTRL_PROG];
   assign s_axi_awready = !awHave_r;
   assign s_axi_wready = !wHave_r;
   assign s_axi_bresp = 2'b00;
   assign s_axi_rresp = 2'b00;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         awHave_r <= 1'b0;
         wHave_r <= 1'b0;
         awAddr_r <= 32'h0000_0000;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && !awHave_r) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHave_r) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // control and configuration registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= 32'h0000_0000;
         setpt_r <= 32'(`SCC_SETPT_RESET);
         bakeTime_r <= 32'(`SCC_BAKETIME_RESET);
         bakeTemp_r <= 32'h0000_0000;
         line_r <= 32'h0000_0003;
         gain_r <= `SCC_ONE_Q16;
         uofs_r <= 32'h0000_0000;
         fs_r <= `SCC_FS_RESET;
         coefIdx_r <= 5'h00;
         raw_r <= 32'h0000_0000;
         heatChan_r <= 6'h00;
      end else begin
         ctrl_r[`SCC_CTRL_TRIG] <= 1'b0;
         ctrl_r[`SCC_CTRL_BAKE] <= 1'b0;
         if (doWrite && wStrb_r != 4'h0) begin
            case (wa)
               `SCC_REG_CTRL: begin
                  ctrl_r[4:0] <= wData_r[4:0];
                  ctrl_r[6:5] <= wData_r[6:5];
                  if (wData_r[`SCC_CTRL_PUNIT] != ctrl_r[`SCC_CTRL_PUNIT]) begin
                     fs_r <= wData_r[`SCC_CTRL_PUNIT] ? qmul(fs_r, `SCC_PSI2BAR)
                                                      : qmul(fs_r, `SCC_BAR2PSI);
                  end
               end
               `SCC_REG_SETPT: if (prog) begin
                  setpt_r <= {16'h0000, wData_r[15:0]};
                  heatChan_r <= wData_r[21:16];
               end
               `SCC_REG_BAKE: if (prog) bakeTime_r <= {16'h0000, wData_r[15:0]};
               `SCC_REG_BAKETMP: if (prog) bakeTemp_r <= {16'h0000, wData_r[15:0]};
               `SCC_REG_LINE: if (prog) line_r <= {27'h0, wData_r[4:0]};
               `SCC_REG_GAIN: gain_r <= wData_r;
               `SCC_REG_UOFS: uofs_r <= wData_r;
               `SCC_REG_FS: fs_r <= wData_r;
               `SCC_REG_COEF: coefIdx_r <= (coefIdx_r == 5'd22) ? 5'd0 : coefIdx_r + 5'd1;
               `SCC_REG_RAW: raw_r <= wData_r;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (doWrite && wa == `SCC_REG_COEF) coef[coefIdx_r] <= wData_r;
   end

   // serial link outputs take fixed values at reset and are never loaded from line_r
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lineRate <= 3'd3;
         parityMode <= 2'd0;
         twoStop <= 1'b0;
      end
   end

   // compensation: raw_r = {rawT[31:16], rawP[15:0]} as Q8.8 each
   wire [31:0] tIn = {{8{raw_r[31]}}, raw_r[31:16], 8'h00};
   wire [31:0] pIn = {{8{raw_r[15]}}, raw_r[15:0], 8'h00};
   wire [31:0] oT = quart(5'd0, tIn);
   wire [31:0] gT = quart(5'd5, tIn);
   wire [31:0] lT = quart(5'd10, tIn);
   wire [31:0] cT = quart(5'd15, tIn);
   wire [31:0] p2 = qmul(pIn, pIn);
   wire [31:0] poly = qmul(cT, qmul(p2, pIn)) + qmul(lT, p2) + qmul(gT, pIn);
   wire [31:0] pct = qmul(gain_r, poly) + oT + uofs_r;
   wire [31:0] tC = qmul(qmul(coef[20], tIn), tIn) + qmul(coef[21], tIn) + coef[22];
   wire [31:0] tOut = ctrl_r[`SCC_CTRL_TUNIT] ? qmul(tC, 32'h0001_CCCD) + 32'h0020_0000
                      : tC;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pres_r <= 32'h0000_0000;
         temp_r <= 32'h0000_0000;
      end else begin
         pres_r <= qmul(pct, fs_r);
         temp_r <= tOut;
      end
   end

   // store one cycle after raw lands, so tOut already reflects it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rawPend_r <= 1'b0;
      else rawPend_r <= doWrite && wa == `SCC_REG_RAW;
   end
   always_ff @(posedge mclk) begin
      if (rawPend_r) chanTemp[wData_r[5:0]] <= tOut[31:16];
   end

   // heater thermostat with bake
   wire [15:0] ctlTemp = chanTemp[heatChan_r];
   wire [15:0] target = (bake_r == SCC_BAKE_RUN) ? bakeTemp_r[15:0] : setpt_r[15:0];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) heaterOn <= 1'b0;
      else if ($signed(ctlTemp) < $signed(target)) heaterOn <= 1'b1;
      else if ($signed(ctlTemp) > $signed(target)) heaterOn <= 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bake_r <= SCC_BAKE_OFF;
         secCnt_r <= 26'd0;
         bakeLeft_r <= 16'h0000;
      end else begin
         case (bake_r)
            SCC_BAKE_OFF, SCC_BAKE_DONE: if (ctrl_r[`SCC_CTRL_BAKE] || cmdBake) begin
               bake_r <= SCC_BAKE_RUN;
               bakeLeft_r <= bakeTime_r[15:0];
               secCnt_r <= 26'd0;
            end
            SCC_BAKE_RUN: begin
               if (bakeLeft_r == 16'h0000) bake_r <= SCC_BAKE_DONE;
               else if (secCnt_r == 26'(`SCC_SEC_CYC - 1)) begin
                  secCnt_r <= 26'd0;
                  bakeLeft_r <= bakeLeft_r - 16'h0001;
               end else secCnt_r <= secCnt_r + 26'd1;
            end
            default: bake_r <= SCC_BAKE_OFF;
         endcase
      end
   end

   // trigger: pin synchronised, falling edge or command
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         trigS1_r <= 1'b1;
         trigS2_r <= 1'b1;
         trigPrev_r <= 1'b1;
      end else begin
         trigS1_r <= trigPin_n;
         trigS2_r <= trigS1_r;
         trigPrev_r <= trigS2_r;
      end
   end
   wire trigEv = (trigPrev_r && !trigS2_r) || ctrl_r[`SCC_CTRL_TRIG] || cmdTrig;
   wire polled = ctrl_r[`SCC_CTRL_POLLED];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sendAll <= 1'b0;
         sendStored <= 1'b0;
         stored_r <= 1'b0;
      end else begin
         sendAll <= trigEv && !polled;
         sendStored <= cmdPoll && stored_r;
         if (trigEv && polled) stored_r <= 1'b1;
         else if (cmdPoll) stored_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) busHold <= 1'b0;
      else busHold <= !ctrl_r[`SCC_CTRL_FREE] || sendAll;
   end

   // ascii command parser fed by CMD register writes
   wire cmdByte = doWrite && wa == `SCC_REG_CMD;
   wire [7:0] ch = wData_r[7:0];
   wire [7:0] haddr = addrAcc_r[7:0];
   wire wordEnd = (ch == 8'h20 || ch == 8'h0D);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         parse_r <= SCC_IDLE;
         addrAcc_r <= 16'h0000;
         word_r <= 16'h0000;
         wordLen_r <= 2'd0;
         addrOk_r <= 1'b0;
         cmdTrig <= 1'b0;
         cmdPoll <= 1'b0;
         cmdBake <= 1'b0;
      end else begin
         cmdTrig <= 1'b0;
         cmdPoll <= 1'b0;
         cmdBake <= 1'b0;
         if (cmdByte) begin
            case (parse_r)
               SCC_IDLE: if (ch == 8'h24) parse_r <= SCC_ADDR1;
                  else if (netPort && ch != 8'h20) begin
                     addrOk_r <= 1'b1;
                     word_r <= {8'h00, ch};
                     wordLen_r <= 2'd1;
                     parse_r <= SCC_WORD;
                  end
               SCC_ADDR1: begin
                  addrAcc_r <= hexNib(ch);
                  parse_r <= SCC_ADDR2;
               end
               SCC_ADDR2: begin
                  addrAcc_r <= {addrAcc_r[11:0], 4'h0} | hexNib(ch);
                  parse_r <= SCC_SPACE;
               end
               SCC_SPACE: if (ch != 8'h20) begin
                  addrOk_r <= (haddr == unitAddr) || (haddr == `SCC_BCAST_ADDR);
                  word_r <= {8'h00, ch};
                  wordLen_r <= 2'd1;
                  parse_r <= SCC_WORD;
               end
               SCC_WORD: if (wordEnd) begin
                  if (addrOk_r) begin
                     cmdTrig <= (word_r == 16'h5452);
                     cmdPoll <= (word_r == 16'h504F);
                     cmdBake <= (word_r == 16'h4241) && prog;
                  end
                  parse_r <= (ch == 8'h0D) ? SCC_IDLE : SCC_SKIP;
               end else if (wordLen_r != 2'd2) begin
                  word_r <= {word_r[7:0], ch};
                  wordLen_r <= wordLen_r + 2'd1;
               end
               SCC_SKIP: if (ch == 8'h0D) parse_r <= SCC_IDLE;
               default: parse_r <= SCC_IDLE;
            endcase
         end
      end
   end

   // read path
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr[7:0])
            `SCC_REG_CTRL: s_axi_rdata <= {25'h0, ctrl_r[6:0]};
            `SCC_REG_SETPT: s_axi_rdata <= {10'h0, heatChan_r, setpt_r[15:0]};
            `SCC_REG_BAKE: s_axi_rdata <= bakeTime_r;
            `SCC_REG_BAKETMP: s_axi_rdata <= bakeTemp_r;
            `SCC_REG_LINE: s_axi_rdata <= line_r;
            `SCC_REG_GAIN: s_axi_rdata <= gain_r;
            `SCC_REG_UOFS: s_axi_rdata <= uofs_r;
            `SCC_REG_FS: s_axi_rdata <= fs_r;
            `SCC_REG_PRES: s_axi_rdata <= pres_r;
            `SCC_REG_TEMP: s_axi_rdata <= temp_r;
            `SCC_REG_STAT: s_axi_rdata <= {bake_r, bakeLeft_r, ctlTemp[7:0], 3'h0,
                                            stored_r, busHold, heaterOn};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end

   a_heat_low: assert property (@(posedge mclk) disable iff (!rst_n)
      $signed(ctlTemp) < $signed(target) |=> heaterOn) else $error("heater not on");
   a_heat_high: assert property (@(posedge mclk) disable iff (!rst_n)
      $signed(ctlTemp) > $signed(target) |=> !heaterOn) else $error("heater not off");
   a_setpt_locked: assert property (@(posedge mclk) disable iff (!rst_n)
      !prog |=> $stable(setpt_r) || $past(!prog) == 1'b0) else $error("setpoint changed");
   a_std_send: assert property (@(posedge mclk) disable iff (!rst_n)
      (trigEv && !polled) |=> sendAll) else $error("no send");
   a_poll_store: assert property (@(posedge mclk) disable iff (!rst_n)
      (trigEv && polled) |=> stored_r && !sendAll) else $error("not stored");
   a_bus_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      !ctrl_r[`SCC_CTRL_FREE] |=> busHold) else $error("bus not held");
   a_line_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 $stable(lineRate) && $stable(parityMode)) else $error("line changed");
   a_bake_done: assert property (@(posedge mclk) disable iff (!rst_n)
      (bake_r == SCC_BAKE_RUN && bakeLeft_r == 16'h0000) |=> bake_r == SCC_BAKE_DONE)
      else $error("bake not done");
endmodule : scc_core

// File: verif/scc_host_model.sv
// Purpose: host side of the scanner: trigger pin and counts of output pulses
// Assumes: mclk domain, trigger pin idles high as if pulled up
// Notes: fire() holds the pin low for a chosen number of cycles, short or long
`timescale 1ns/1ns
module scc_host_model (
   input wire logic mclk,
   input wire logic rst_n,
   output logic trigPin_n,
   input wire logic sendAll,
   input wire logic sendStored,
   output int allCnt,
   output int storedCnt
);
   initial trigPin_n = 1'b1;

   // hardware trigger, prompt or slow release
   task automatic fire(input int lowCyc);
      begin
         @(posedge mclk);
         trigPin_n <= 1'b0;
         repeat (lowCyc) @(posedge mclk);
         trigPin_n <= 1'b1;
      end
   endtask : fire

   // count data bursts the unit starts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         allCnt <= 0;
         storedCnt <= 0;
      end else begin
         if (sendAll) allCnt <= allCnt + 1;
         if (sendStored) storedCnt <= storedCnt + 1;
      end
   end
endmodule : scc_host_model

// File: verif/scc_core_bench.sv
// Purpose: self-checking bench for scc_core
// Assumes: 50 MHz mclk, AXI4-Lite master in the bench, host model on trigger pin
// Notes: command bytes go one per write to the command register
`timescale 1ns/1ns
`include "scc_map.svh"
module scc_core_bench;
   logic mclk, rst_n;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [1:0] s_axi_bresp, s_axi_rresp, parityMode;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, trigPin_n, netPort;
   logic [7:0] unitAddr, own;
   logic heaterOn, busHold, sendAll, sendStored, twoStop;
   logic [2:0] lineRate;
   logic [31:0] got, v;
   int allCnt, storedCnt, expA, expS, err_total, checked, seed;
   logic [7:0] regA [2] = '{`SCC_REG_SETPT, `SCC_REG_BAKE};
   logic [31:0] rstV [2] = '{32'h0000_0014, 32'h0000_0E10};
   logic [31:0] mskV [2] = '{32'h003F_FFFF, 32'h0000_FFFF};

   scc_core dut_u (
      .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .trigPin_n, .netPort, .unitAddr, .heaterOn, .busHold,
      .sendAll, .sendStored, .lineRate, .parityMode, .twoStop
   );
   scc_host_model host_u (
      .mclk, .rst_n, .trigPin_n, .sendAll, .sendStored, .allCnt, .storedCnt
   );

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checked, err_total);
         if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         checked++;
         if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask : chk

   task automatic tmo;
      begin
         err_total++;
         $display("unexpected at %0t: wait ran out", $time);
         tally_and_finish;
      end
   endtask : tmo

   function automatic logic [31:0] ra(input logic [7:0] o);
      return {24'h00_0000, o};
   endfunction : ra

   function automatic logic [7:0] hexc(input logic [3:0] h);
      return (h < 4'hA) ? 8'h30 + 8'(h) : 8'h37 + 8'(h);
   endfunction : hexc

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge mclk);
         s_axi_awaddr <= ra(a);
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge mclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (!s_axi_bvalid && n < 200);
         s_axi_bready <= 1'b0;
         if (n >= 200) tmo;
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge mclk);
         s_axi_araddr <= ra(a);
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge mclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid && n < 200);
         d = s_axi_rdata;
         s_axi_rready <= 1'b0;
         if (n >= 200) tmo;
      end
   endtask : rd

   task automatic cmd(input bit withAddr, input logic [7:0] ad, input string w);
      begin
         if (withAddr) begin
            wr(`SCC_REG_CMD, 32'h0000_0024);
            wr(`SCC_REG_CMD, {24'h00_0000, hexc(ad[7:4])});
            wr(`SCC_REG_CMD, {24'h00_0000, hexc(ad[3:0])});
            wr(`SCC_REG_CMD, 32'h0000_0020);
         end
         for (int i = 0; i < w.len(); i++) wr(`SCC_REG_CMD, {24'h00_0000, w[i]});
         wr(`SCC_REG_CMD, 32'h0000_000D);
      end
   endtask : cmd

   // bursts seen must reach the expected counts and stay there
   task automatic await(input int ea, input int es);
      int n;
      begin
         n = 0;
         while ((allCnt != ea || storedCnt != es) && n < 2000) begin
            @(posedge mclk);
            n++;
         end
         repeat (8) @(posedge mclk);
         chk(32'(allCnt), 32'(ea));
         chk(32'(storedCnt), 32'(es));
      end
   endtask : await

   initial begin
      seed = 32'hbe8a2e0b;
      v = $random(seed);
      own = {1'b0, v[6:1], 1'b0};
      rst_n = 1'b0;
      s_axi_awaddr = '0;
      s_axi_wdata = '0;
      s_axi_araddr = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      netPort = 1'b0;
      unitAddr = own;
      expA = 0;
      expS = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'(busHold), 32'h0000_0001);
      chk(32'(lineRate), 32'h0000_0003);
      chk(32'(parityMode), 32'h0000_0000);
      chk(32'(twoStop), 32'h0000_0000);
      rd(`SCC_REG_FS, got);
      chk(got, `SCC_FS_RESET);
      rd(8'h40, got);
      chk(got, 32'h0000_0000);
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         v = $random(seed);
         wr(`SCC_REG_CTRL, 32'h0000_0000);
         wr(regA[k], v);
         rd(regA[k], got);
         chk(got, rstV[k]);
         wr(`SCC_REG_CTRL, 32'h0000_0001);
         wr(regA[k], v);
         rd(regA[k], got);
         chk(got, v & mskV[k]);
      end
      wr(`SCC_REG_LINE, $random(seed));
      repeat (3) @(posedge mclk);
      chk(32'(lineRate), 32'h0000_0003);
      chk(32'(parityMode), 32'h0000_0000);
      chk(32'(twoStop), 32'h0000_0000);
      $display("test programming done");
      wr(`SCC_REG_CTRL, 32'h0000_0010);
      repeat (3) @(posedge mclk);
      chk(32'(busHold), 32'h0000_0000);
      wr(`SCC_REG_CTRL, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      chk(32'(busHold), 32'h0000_0001);
      wr(`SCC_REG_CTRL, 32'h0000_0004);
      rd(`SCC_REG_FS, got);
      chk(got, 32'h0000_1197);
      wr(`SCC_REG_CTRL, 32'h0000_0000);
      $display("test release and units done");
      host_u.fire(2);
      expA++;
      await(expA, expS);
      cmd(1, own, "TR");
      expA++;
      await(expA, expS);
      cmd(1, own, "TRIGGER");
      expA++;
      await(expA, expS);
      cmd(1, own | 8'h01, "TR");
      await(expA, expS);
      cmd(1, 8'hFF, "TR");
      expA++;
      await(expA, expS);
      netPort <= 1'b1;
      cmd(0, 8'h00, "TR");
      expA++;
      await(expA, expS);
      netPort <= 1'b0;
      host_u.fire(40);
      expA++;
      await(expA, expS);
      $display("test standard trigger done");
      wr(`SCC_REG_CTRL, 32'h0000_0008);
      host_u.fire(2);
      await(expA, expS);
      cmd(1, own, "PO");
      expS++;
      await(expA, expS);
      cmd(1, own, "PO");
      await(expA, expS);
      $display("test polled trigger done");
      wr(`SCC_REG_CTRL, 32'h0000_0001);
      rd(`SCC_REG_STAT, got);
      chk(32'(got[31:30]), 32'h0000_0000);
      for (int i = 0; i < 23; i++) begin
         wr(`SCC_REG_COEF, (i == 9) ? `SCC_ONE_Q16 : (i == 22) ? 32'h0019_0000 : 32'h0000_0000);
      end
      wr(`SCC_REG_FS, 32'h000A_0000);
      v = $random(seed);
      wr(`SCC_REG_RAW, {v[31:16], 16'h0200});
      repeat (3) @(posedge mclk);
      rd(`SCC_REG_PRES, got);
      chk(got, 32'h0014_0000);
      rd(`SCC_REG_TEMP, got);
      chk(got, 32'h0019_0000);
      wr(`SCC_REG_CTRL, 32'h0000_0003);
      rd(`SCC_REG_TEMP, got);
      chk(32'(got[31:16]), 32'h0000_004D);
      wr(`SCC_REG_CTRL, 32'h0000_0001);
      wr(`SCC_REG_SETPT, 32'h0000_001E);
      repeat (3) @(posedge mclk);
      chk(32'(heaterOn), 32'h0000_0001);
      wr(`SCC_REG_SETPT, 32'h0000_0014);
      repeat (3) @(posedge mclk);
      chk(32'(heaterOn), 32'h0000_0000);
      $display("test compensation and heater done");
      wr(`SCC_REG_BAKE, 32'h0000_0000);
      wr(`SCC_REG_CTRL, 32'h0000_0041);
      rd(`SCC_REG_STAT, got);
      chk(32'(got[31:30]), 32'h0000_0003);
      wr(`SCC_REG_BAKE, 32'h0000_0003);
      cmd(1, own, "BA");
      rd(`SCC_REG_STAT, got);
      chk(32'(got[31:14]), 32'h0001_0003);
      $display("test bake done");
      tally_and_finish;
   end
endmodule : scc_core_bench
